// ---- hw/coef_pkg.sv ----
// Purpose: shared constants, types and helpers of the right-channel
//          coefficient bank and its filter stages
// Assumes: APB data is 32 bits, registers are 8 bits in the low lane
// Notes:   register offsets are indices; byte address is index times four
package coef_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int STRB_W = 4;
    localparam int IDX_W = 6;
    localparam int COEF_W = 16;
    localparam int PROD_W = 32;
    localparam int ACC_W = 34;
    localparam int FRAC_BITS = 15;

    // address field layout of paddr
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 7;
    localparam int ADDR_TOP_LSB = 8;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;
    localparam logic [3:0] ADDR_TOP = 4'h0;

    // register indices
    localparam logic [IDX_W-1:0] IDX_EFFECTS_NUM5_HIGH = 6'h25;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_NUM5_LOW = 6'h26;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN1_HIGH = 6'h27;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN1_LOW = 6'h28;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN2_HIGH = 6'h29;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN2_LOW = 6'h2A;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN4_HIGH = 6'h2B;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN4_LOW = 6'h2C;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN5_HIGH = 6'h2D;
    localparam logic [IDX_W-1:0] IDX_EFFECTS_DEN5_LOW = 6'h2E;
    localparam logic [IDX_W-1:0] IDX_DEEMPH_NUM0_HIGH = 6'h2F;
    localparam logic [IDX_W-1:0] IDX_DEEMPH_NUM0_LOW = 6'h30;
    localparam logic [IDX_W-1:0] IDX_FILTER_CONTROL = 6'h3C;
    localparam logic [IDX_W-1:0] IDX_FILTER_STATUS = 6'h3D;

    localparam int COEF_COUNT = 12;
    localparam int SLOT_W = 4;

    // reset values
    localparam logic [7:0] RST_EFFECTS_NUM5_HIGH = 8'h67;
    localparam logic [7:0] RST_EFFECTS_NUM5_LOW = 8'h5D;
    localparam logic [7:0] RST_EFFECTS_DEN1_HIGH = 8'h7D;
    localparam logic [7:0] RST_EFFECTS_DEN1_LOW = 8'h83;
    localparam logic [7:0] RST_EFFECTS_DEN2_HIGH = 8'h84;
    localparam logic [7:0] RST_EFFECTS_DEN2_LOW = 8'hEE;
    localparam logic [7:0] RST_EFFECTS_DEN4_HIGH = 8'h7D;
    localparam logic [7:0] RST_EFFECTS_DEN4_LOW = 8'h83;
    localparam logic [7:0] RST_EFFECTS_DEN5_HIGH = 8'h84;
    localparam logic [7:0] RST_EFFECTS_DEN5_LOW = 8'hEE;
    localparam logic [7:0] RST_DEEMPH_NUM0_HIGH = 8'h39;
    localparam logic [7:0] RST_DEEMPH_NUM0_LOW = 8'h55;
    localparam logic [7:0] RST_FILTER_CONTROL = 8'h00;

    localparam logic [7:0] COEF_RESET [0:COEF_COUNT-1] = '{
        RST_EFFECTS_NUM5_HIGH, RST_EFFECTS_NUM5_LOW,
        RST_EFFECTS_DEN1_HIGH, RST_EFFECTS_DEN1_LOW,
        RST_EFFECTS_DEN2_HIGH, RST_EFFECTS_DEN2_LOW,
        RST_EFFECTS_DEN4_HIGH, RST_EFFECTS_DEN4_LOW,
        RST_EFFECTS_DEN5_HIGH, RST_EFFECTS_DEN5_LOW,
        RST_DEEMPH_NUM0_HIGH, RST_DEEMPH_NUM0_LOW
    };

    // control and status fields
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int STAT_SAT_BIT = 0;

    localparam logic signed [ACC_W-1:0] ACC_MAX = 34'sh0_0000_7FFF;
    localparam logic signed [ACC_W-1:0] ACC_MIN = -34'sh0_0000_8000;
    localparam logic signed [COEF_W-1:0] SAMPLE_MAX = 16'sh7FFF;
    localparam logic signed [COEF_W-1:0] SAMPLE_MIN = -16'sh8000;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ANSWER = 2'b10
    } apb_state_type;

    // high byte on top, low byte below, read as two's complement
    function automatic logic signed [COEF_W-1:0] coef_word(
        input logic [BYTE_W-1:0] high_byte,
        input logic [BYTE_W-1:0] low_byte);
        coef_word = $signed({high_byte, low_byte});
    endfunction

    function automatic logic signed [COEF_W-1:0] sat_sample(
        input logic signed [ACC_W-1:0] acc);
        if (acc > ACC_MAX) begin
            sat_sample = SAMPLE_MAX;
        end else if (acc < ACC_MIN) begin
            sat_sample = SAMPLE_MIN;
        end else begin
            sat_sample = acc[COEF_W-1:0];
        end
    endfunction

endpackage

// ---- hw/coef_biquad.sv ----
// Purpose: one recursive filter stage driven by live coefficient words
// Assumes: coefficients are Q1.15 two's complement, samples 16-bit signed
// Notes:   one result per accepted sample, saturated to the sample range
`timescale 1ns/1ps
module coef_biquad (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic signed [coef_pkg::COEF_W-1:0] in_sample,
    input wire logic signed [coef_pkg::COEF_W-1:0] feed_coef,
    input wire logic signed [coef_pkg::COEF_W-1:0] back_coef_one,
    input wire logic signed [coef_pkg::COEF_W-1:0] back_coef_two,
    output logic out_valid,
    output logic signed [coef_pkg::COEF_W-1:0] out_sample,
    output logic saturated
);

    logic signed [coef_pkg::COEF_W-1:0] hist1_r;
    logic signed [coef_pkg::COEF_W-1:0] hist2_r;
    logic signed [coef_pkg::PROD_W-1:0] prod_feed;
    logic signed [coef_pkg::PROD_W-1:0] prod_one;
    logic signed [coef_pkg::PROD_W-1:0] prod_two;
    logic signed [coef_pkg::ACC_W-1:0] acc_sum;
    logic signed [coef_pkg::ACC_W-1:0] acc_scaled;
    logic signed [coef_pkg::COEF_W-1:0] sample_nxt;
    logic sat_nxt;

    // signed products keep the full negative range of every coefficient
    assign prod_feed = feed_coef * in_sample;
    assign prod_one = back_coef_one * hist1_r;
    assign prod_two = back_coef_two * hist2_r;
    assign acc_sum = coef_pkg::ACC_W'(prod_feed) + coef_pkg::ACC_W'(prod_one)
        + coef_pkg::ACC_W'(prod_two);
    assign acc_scaled = acc_sum >>> coef_pkg::FRAC_BITS;
    assign sample_nxt = coef_pkg::sat_sample(acc_scaled);
    assign sat_nxt = (acc_scaled > coef_pkg::ACC_MAX)
        || (acc_scaled < coef_pkg::ACC_MIN);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hist1_r <= '0;
            hist2_r <= '0;
            out_sample <= '0;
            out_valid <= 1'b0;
            saturated <= 1'b0;
        end else begin
            out_valid <= in_valid;
            saturated <= in_valid & sat_nxt;
            if (in_valid) begin
                hist2_r <= hist1_r;
                hist1_r <= sample_nxt;
                out_sample <= sample_nxt;
            end
        end
    end

endmodule

// ---- hw/right_effects_coeff_regs.sv ----
// Purpose: right-channel effects and de-emphasis coefficient bank on APB,
//          with the filter stages that consume the coefficients
// Assumes: one APB wait state; samples arrive on clk as one-cycle strobes
// Notes:   coefficient byte registers sit at index*4 in the low data lane
//
// Contract
// - Each coefficient is high byte over low byte, one 16-bit word.
// - Every assembled coefficient is a signed two's complement value.
// - Fifth numerator low byte resets to 0x5D.
// - First denominator resets to high 0x7D, low 0x83.
// - Second denominator resets to high 0x84, low 0xEE.
// - Fourth denominator resets to high 0x7D, low 0x83.
// - Fifth denominator resets to high 0x84, low 0xEE.
// - De-emphasis zeroth numerator high byte resets to 0x39.
// - Fifth numerator high byte resets to 0x67.
// - De-emphasis zeroth numerator low byte resets to 0x55.
`timescale 1ns/1ps
module right_effects_coeff_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [coef_pkg::ADDR_W-1:0] paddr,
    input wire logic [coef_pkg::DATA_W-1:0] pwdata,
    input wire logic [coef_pkg::STRB_W-1:0] pstrb,
    output logic [coef_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic signed [coef_pkg::COEF_W-1:0] sample_in,
    output logic sample_out_valid,
    output logic signed [coef_pkg::COEF_W-1:0] sample_out
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------

    logic [coef_pkg::BYTE_W-1:0] coef_r [0:coef_pkg::COEF_COUNT-1];
    logic [coef_pkg::BYTE_W-1:0] control_r;
    logic sat_seen_r;

    coef_pkg::apb_state_type state_r;
    coef_pkg::apb_state_type state_nxt;

    logic [coef_pkg::DATA_W-1:0] prdata_nxt;
    logic pslverr_nxt;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    logic [coef_pkg::IDX_W-1:0] addr_idx;
    logic [coef_pkg::IDX_W-1:0] coef_offset;
    logic [coef_pkg::SLOT_W-1:0] coef_slot;
    logic addr_aligned;
    logic hit_coef;
    logic hit_control;
    logic hit_status;
    logic addr_mapped;

    assign addr_idx = paddr[coef_pkg::ADDR_IDX_MSB:coef_pkg::ADDR_IDX_LSB];
    assign addr_aligned =
        (paddr[coef_pkg::ADDR_IDX_LSB-1:0] == coef_pkg::ADDR_ALIGN)
        && (paddr[coef_pkg::ADDR_W-1:coef_pkg::ADDR_TOP_LSB]
            == coef_pkg::ADDR_TOP);
    assign coef_offset = addr_idx - coef_pkg::IDX_EFFECTS_NUM5_HIGH;
    assign coef_slot = coef_offset[coef_pkg::SLOT_W-1:0];
    assign hit_coef = addr_aligned
        && (addr_idx >= coef_pkg::IDX_EFFECTS_NUM5_HIGH)
        && (addr_idx <= coef_pkg::IDX_DEEMPH_NUM0_LOW);
    assign hit_control = addr_aligned
        && (addr_idx == coef_pkg::IDX_FILTER_CONTROL);
    assign hit_status = addr_aligned
        && (addr_idx == coef_pkg::IDX_FILTER_STATUS);
    assign addr_mapped = hit_coef || hit_control || hit_status;

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------

    // the access phase is seen once in idle, answered one cycle later
    logic access_seen;
    logic commit;
    logic write_commit;
    logic lane0_write;

    assign access_seen = psel && penable;
    assign commit = access_seen && (state_r == coef_pkg::APB_ANSWER);
    assign write_commit = commit && pwrite && addr_mapped;
    assign lane0_write = write_commit && pstrb[0];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            coef_pkg::APB_IDLE: begin
                if (access_seen) begin
                    state_nxt = coef_pkg::APB_ANSWER;
                end
            end
            coef_pkg::APB_ANSWER: begin
                state_nxt = coef_pkg::APB_IDLE;
            end
            default: begin
                state_nxt = coef_pkg::APB_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    logic [coef_pkg::BYTE_W-1:0] read_byte;
    logic [coef_pkg::BYTE_W-1:0] status_byte;

    assign status_byte = {{(coef_pkg::BYTE_W-1){1'b0}}, sat_seen_r};
    assign read_byte = hit_coef ? coef_r[coef_slot]
        : hit_control ? control_r
        : hit_status ? status_byte
        : '0;

    // upper lanes always read zero
    assign prdata_nxt = (!pwrite && addr_mapped)
        ? {{(coef_pkg::DATA_W-coef_pkg::BYTE_W){1'b0}}, read_byte}
        : '0;
    assign pslverr_nxt = !addr_mapped;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= coef_pkg::APB_IDLE;
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pready <= (state_nxt == coef_pkg::APB_ANSWER);
            if (state_r == coef_pkg::APB_IDLE && access_seen) begin
                prdata <= prdata_nxt;
                pslverr <= pslverr_nxt;
            end else begin
                prdata <= '0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // coefficient bank
    // ------------------------------------------------------------------

    // every byte of the bank is plain read/write over all eight bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < coef_pkg::COEF_COUNT; i++) begin
                coef_r[i] <= coef_pkg::COEF_RESET[i];
            end
        end else if (lane0_write && hit_coef) begin
            coef_r[coef_slot] <= pwdata[coef_pkg::BYTE_W-1:0];
        end
    end
    // reset table order

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            control_r <= coef_pkg::RST_FILTER_CONTROL;
        end else if (lane0_write && hit_control) begin
            control_r <= pwdata[coef_pkg::BYTE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // coefficient words
    // ------------------------------------------------------------------

    localparam int S_N5H = 0;
    localparam int S_N5L = 1;
    localparam int S_D1H = 2;
    localparam int S_D1L = 3;
    localparam int S_D2H = 4;
    localparam int S_D2L = 5;
    localparam int S_D4H = 6;
    localparam int S_D4L = 7;
    localparam int S_D5H = 8;
    localparam int S_D5L = 9;
    localparam int S_N0H = 10;
    localparam int S_N0L = 11;

    logic signed [coef_pkg::COEF_W-1:0] numerator_coef_five;
    logic signed [coef_pkg::COEF_W-1:0] denominator_coef_one;
    logic signed [coef_pkg::COEF_W-1:0] denominator_coef_two;
    logic signed [coef_pkg::COEF_W-1:0] denominator_coef_four;
    logic signed [coef_pkg::COEF_W-1:0] denominator_coef_five;
    logic signed [coef_pkg::COEF_W-1:0] numerator_coef_zero;

    // words are rebuilt combinationally, so a write lands on the next sample
    assign numerator_coef_five =
        coef_pkg::coef_word(coef_r[S_N5H], coef_r[S_N5L]);
    assign denominator_coef_one =
        coef_pkg::coef_word(coef_r[S_D1H], coef_r[S_D1L]);
    assign denominator_coef_two =
        coef_pkg::coef_word(coef_r[S_D2H], coef_r[S_D2L]);
    assign denominator_coef_four =
        coef_pkg::coef_word(coef_r[S_D4H], coef_r[S_D4L]);
    assign denominator_coef_five =
        coef_pkg::coef_word(coef_r[S_D5H], coef_r[S_D5L]);
    assign numerator_coef_zero =
        coef_pkg::coef_word(coef_r[S_N0H], coef_r[S_N0L]);

    // ------------------------------------------------------------------
    // filter datapath
    // ------------------------------------------------------------------

    logic bypass;
    logic stage_a_valid;
    logic signed [coef_pkg::COEF_W-1:0] stage_a_sample;
    logic stage_a_sat;
    logic stage_b_valid;
    logic signed [coef_pkg::COEF_W-1:0] stage_b_sample;
    logic stage_b_sat;

    assign bypass = control_r[coef_pkg::CTRL_BYPASS_BIT];

    coef_biquad effects_stage (
        .clk(clk),
        .nrst(nrst),
        .in_valid(sample_valid && !bypass),
        .in_sample(sample_in),
        .feed_coef(numerator_coef_five),
        .back_coef_one(denominator_coef_one),
        .back_coef_two(denominator_coef_two),
        .out_valid(stage_a_valid),
        .out_sample(stage_a_sample),
        .saturated(stage_a_sat)
    );

    coef_biquad shelving_stage (
        .clk(clk),
        .nrst(nrst),
        .in_valid(stage_a_valid),
        .in_sample(stage_a_sample),
        .feed_coef(numerator_coef_zero),
        .back_coef_one(denominator_coef_four),
        .back_coef_two(denominator_coef_five),
        .out_valid(stage_b_valid),
        .out_sample(stage_b_sample),
        .saturated(stage_b_sat)
    );

    // bypass is quicker than the filtered path; switching it mid-stream
    // can drop the two samples still in flight
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sample_out_valid <= 1'b0;
            sample_out <= '0;
        end else if (bypass) begin
            sample_out_valid <= sample_valid;
            if (sample_valid) begin
                sample_out <= sample_in;
            end
        end else begin
            sample_out_valid <= stage_b_valid;
            if (stage_b_valid) begin
                sample_out <= stage_b_sample;
            end
        end
    end

    // ------------------------------------------------------------------
    // saturation status
    // ------------------------------------------------------------------

    logic sat_event;
    logic sat_clear;

    assign sat_event = stage_a_sat || stage_b_sat;
    assign sat_clear = lane0_write && hit_status
        && pwdata[coef_pkg::STAT_SAT_BIT];

    // a new clip in the clearing cycle keeps the flag set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sat_seen_r <= 1'b0;
        end else if (sat_event) begin
            sat_seen_r <= 1'b1;
        end else if (sat_clear) begin
            sat_seen_r <= 1'b0;
        end
    end

endmodule

// ---- tb/right_effects_coeff_regs_props.sv ----
// Purpose: concurrent checks on the coefficient bank ports
// Assumes: one clock domain, nrst low clears every output
// Notes:   bypass answers in one edge and filtering in three, so the
//          output cause check accepts both
`timescale 1ns/1ps
module right_effects_coeff_regs_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic signed [15:0] sample_in,
    input wire logic sample_out_valid,
    input wire logic signed [15:0] sample_out
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    answer_timing_a: assert property (
        psel && $rose(penable) |=> pready)
        else $error("no answer one cycle after the access phase began");
    idle_no_answer_a: assert property (
        !psel |=> !pready && !pslverr)
        else $error("answer without a selected transfer");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside an answer");
    rdata_lane_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without pready");
    misalign_err_a: assert property (
        psel && $rose(penable) && (paddr[1:0] != 2'h0 || paddr[11:8] != 4'h0)
        |=> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    mapped_ok_a: assert property (
        psel && $rose(penable) && paddr >= 12'h094 && paddr <= 12'h0C0
        && paddr[1:0] == 2'h0 |=> pready && !pslverr)
        else $error("mapped coefficient access refused");
    out_cause_a: assert property (
        sample_out_valid |-> $past(sample_valid, 3) || $past(sample_valid))
        else $error("result strobe without a sample before it");
    out_hold_a: assert property (
        !sample_out_valid |-> $stable(sample_out))
        else $error("result changed without its strobe");
endmodule

bind right_effects_coeff_regs right_effects_coeff_regs_props chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .sample_out_valid(sample_out_valid), .sample_out(sample_out)
);

// ---- tb/tb_top.sv ----
// Purpose: directed bench for the right-channel coefficient bank
// Assumes: bypass is on in one scenario only; answers come within a few cycles
// Notes:   filter expectations are hand worked Q1.15 products
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_valid = 1'b0;
    logic signed [15:0] sample_in = 16'sh0000;
    logic sample_out_valid;
    logic signed [15:0] sample_out;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checks_done = 0;

    always #10 clk = ~clk;

    right_effects_coeff_regs dut (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_in(sample_in),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out)
    );

    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [11:0] ad(input logic [5:0] i);
        return {4'h0, i, 2'h0};
    endfunction

    // a timed-out wait ends the run rather than leaving a stuck bus
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, ad(i), 32'h0, 4'hF);
        chk(rd, {24'h0, e});
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic reset_values;
        rd_chk(coef_pkg::IDX_EFFECTS_NUM5_HIGH, 8'h67);
        rd_chk(coef_pkg::IDX_EFFECTS_NUM5_LOW, 8'h5D);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN1_HIGH, 8'h7D);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN1_LOW, 8'h83);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN2_HIGH, 8'h84);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN2_LOW, 8'hEE);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN4_HIGH, 8'h7D);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN4_LOW, 8'h83);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN5_HIGH, 8'h84);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN5_LOW, 8'hEE);
        rd_chk(coef_pkg::IDX_DEEMPH_NUM0_HIGH, 8'h39);
        rd_chk(coef_pkg::IDX_DEEMPH_NUM0_LOW, 8'h55);
    endtask

    // all writes land before any read, so aliasing between places shows
    task automatic readback;
        logic [5:0] i;
        for (int k = 0; k < 12; k++) begin
            i = coef_pkg::IDX_EFFECTS_NUM5_HIGH + 6'(k);
            apb(1'b1, ad(i), {24'hFFFFFF, 4'(k), ~4'(k)}, 4'hF);
        end
        for (int k = 0; k < 12; k++) begin
            i = coef_pkg::IDX_EFFECTS_NUM5_HIGH + 6'(k);
            rd_chk(i, {4'(k), ~4'(k)});
        end
        apb(1'b1, ad(coef_pkg::IDX_EFFECTS_DEN1_HIGH), 32'hAA, 4'h0);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN1_HIGH, 8'h2D);
    endtask

    task automatic refusals;
        apb(1'b0, ad(6'h31), 32'h0, 4'hF);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h09D, 32'h11, 4'hF);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h19C, 32'h22, 4'hF);
        chk({31'h0, err}, 32'h1);
        rd_chk(coef_pkg::IDX_EFFECTS_DEN1_HIGH, 8'h2D);
    endtask

    task automatic send(input logic [15:0] x, input logic [15:0] e,
                        input int lat);
        int n;
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_in <= x;
        @(posedge clk);
        sample_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sample_out_valid !== 1'b1 && n < 10);
        if (sample_out_valid !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        chk(lat, 32'(n));
        chk({16'h0, sample_out}, {16'h0, e});
    endtask

    // num5 0x0080 and num0 0x8000: a swapped byte pair or an unsigned
    // reading gives a different result at once
    task automatic filter_math;
        logic [7:0] cfg [12] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
        for (int k = 0; k < 12; k++) begin
            apb(1'b1, ad(coef_pkg::IDX_EFFECTS_NUM5_HIGH + 6'(k)),
                {24'h0, cfg[k]}, 4'hF);
        end
        send(16'h4000, 16'hFFC0, 3);
        apb(1'b1, ad(coef_pkg::IDX_EFFECTS_NUM5_LOW), 32'h40, 4'hF);
        send(16'h4000, 16'hFFE0, 3);
        apb(1'b1, ad(coef_pkg::IDX_EFFECTS_DEN4_HIGH), 32'h40, 4'hF);
        send(16'h4000, 16'hFFD0, 3);
    endtask

    // bypass hands the sample straight through and leaves filter state alone
    task automatic bypass_path;
        apb(1'b1, ad(coef_pkg::IDX_FILTER_CONTROL), 32'h1, 4'hF);
        rd_chk(coef_pkg::IDX_FILTER_CONTROL, 8'h01);
        send(16'h1234, 16'h1234, 1);
        apb(1'b1, ad(coef_pkg::IDX_FILTER_CONTROL), 32'h0, 4'hF);
        rd_chk(coef_pkg::IDX_FILTER_CONTROL, 8'h00);
    endtask

    // num5 at its most negative squares -32768 past full scale, stage B
    // then clips low; the sticky flag must clear on a write of one
    task automatic sat_status;
        apb(1'b1, ad(coef_pkg::IDX_EFFECTS_NUM5_HIGH), 32'h80, 4'hF);
        apb(1'b1, ad(coef_pkg::IDX_EFFECTS_NUM5_LOW), 32'h00, 4'hF);
        rd_chk(coef_pkg::IDX_FILTER_STATUS, 8'h00);
        send(16'h8000, 16'h8000, 3);
        rd_chk(coef_pkg::IDX_FILTER_STATUS, 8'h01);
        apb(1'b1, ad(coef_pkg::IDX_FILTER_STATUS), 32'h1, 4'hF);
        rd_chk(coef_pkg::IDX_FILTER_STATUS, 8'h00);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        reset_values();
        readback();
        refusals();
        filter_math();
        bypass_path();
        sat_status();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(coef_pkg::IDX_EFFECTS_DEN1_LOW, 8'h83);
        chk({16'h0, sample_out}, 32'h0);
        end_of_test();
    end
endmodule
